// ---- rtl/ucil_map.svh ----
// Register offsets, field positions, reset values and codes of the block
`ifndef UCIL_MAP_SVH
`define UCIL_MAP_SVH
`define UCIL_ADR_RXHOLD 4'h0
`define UCIL_ADR_MASK 4'h1
`define UCIL_ADR_SRC 4'h2
`define UCIL_ADR_MCTL 4'h4
`define UCIL_ADR_LSTAT 4'h5
`define UCIL_ADR_MSTAT 4'h6
`define UCIL_ADR_FCTL 4'h8
`define UCIL_ADR_ENH 4'h9
`define UCIL_ADR_TXLVL 4'hA
`define UCIL_ADR_RXLVL 4'hB
`define UCIL_MASK_RX 0
`define UCIL_MASK_TX 1
`define UCIL_MASK_LS 2
`define UCIL_MASK_MS 3
`define UCIL_MASK_RSVD 4
`define UCIL_MASK_XOFF 5
`define UCIL_MASK_RTS 6
`define UCIL_MASK_CTS 7
`define UCIL_ENH_UNLOCK 4
`define UCIL_ENH_AUTO_RTS 6
`define UCIL_ENH_AUTO_CTS 7
`define UCIL_FCTL_AUTO485 5
`define UCIL_MCTL_PAIR 2
`define UCIL_FIFO_EN 0
`define UCIL_FIFO_RXRST 1
`define UCIL_FIFO_TXRST 2
`define UCIL_SRC_LS 6'h06
`define UCIL_SRC_RXD 6'h04
`define UCIL_SRC_TMO 6'h0C
`define UCIL_SRC_TX 6'h02
`define UCIL_SRC_MS 6'h00
`define UCIL_SRC_XCH 6'h10
`define UCIL_SRC_PIN 6'h20
`define UCIL_SRC_NONE 6'h01
`define UCIL_RST_SRC 8'h01
`define UCIL_RST_REG 8'h00
`define UCIL_TMO_CHARS 4
`define UCIL_TMO_EXTRA_BITS 12
`endif

// ---- rtl/ucil_pkg.sv ----
// State record types of the channel interrupt logic
package ucil_pkg;
    typedef struct packed {
        logic [7:0] mask;
        logic fifo_en;
        logic [1:0] rx_sel;
        logic [1:0] tx_sel;
        logic [7:0] mctl;
        logic [7:0] fctl;
        logic [7:0] enh;
        logic [7:0] rxlvl;
        logic [7:0] txlvl;
        logic ls_p;
        logic tmo_p;
        logic tx_p;
        logic xch_p;
        logic spc_p;
        logic pin_p;
        logic wake;
        logic cts_q;
        logic rts_q;
        logic head_q;
        logic hold_q;
        logic empty_q;
        logic above_q;
        logic [7:0] rdata;
        logic irq;
        logic rx_rst;
        logic tx_rst;
    } ucil_state_type;

    typedef struct packed {
        logic [7:0] cnt;
        logic fired;
        logic expire;
    } ucil_tmo_type;
endpackage : ucil_pkg

// ---- rtl/ucil_trig_sel.sv ----
// Trigger level lookup from the selected table and selection bits
`timescale 1ns/1ps
`include "ucil_map.svh"
module ucil_trig_sel
    import ucil_pkg::*;
(
    input wire logic [1:0] table_sel, // Table choice
    input wire logic [1:0] rx_sel, // Receive level index
    input wire logic [1:0] tx_sel, // Transmit level index
    input wire logic [7:0] rxlvl, // Programmed receive level
    input wire logic [7:0] txlvl, // Programmed transmit level
    output logic [7:0] rx_lvl, // Active receive trigger
    output logic [7:0] tx_lvl // Active transmit trigger
);
    // Fixed tables; index {table, is_tx, sel}
    function automatic logic [7:0] ucil_lvl(input logic [4:0] idx);
        unique case (idx)
            5'h00: ucil_lvl = 8'h01;
            5'h01: ucil_lvl = 8'h04;
            5'h02: ucil_lvl = 8'h08;
            5'h03: ucil_lvl = 8'h0E;
            5'h04, 5'h05, 5'h06, 5'h07: ucil_lvl = 8'h01;
            5'h08: ucil_lvl = 8'h08;
            5'h09: ucil_lvl = 8'h10;
            5'h0A: ucil_lvl = 8'h18;
            5'h0B: ucil_lvl = 8'h1C;
            5'h0C: ucil_lvl = 8'h10;
            5'h0D: ucil_lvl = 8'h08;
            5'h0E: ucil_lvl = 8'h18;
            5'h0F: ucil_lvl = 8'h1E;
            5'h10: ucil_lvl = 8'h08;
            5'h11: ucil_lvl = 8'h10;
            5'h12: ucil_lvl = 8'h38;
            5'h13: ucil_lvl = 8'h3C;
            5'h14: ucil_lvl = 8'h08;
            5'h15: ucil_lvl = 8'h10;
            5'h16: ucil_lvl = 8'h20;
            5'h17: ucil_lvl = 8'h38;
            default: ucil_lvl = 8'h01;
        endcase
    endfunction : ucil_lvl

    always_comb begin
        if (table_sel == 2'h3) begin
            rx_lvl = rxlvl;
            tx_lvl = txlvl;
        end else begin
            rx_lvl = ucil_lvl({table_sel, 1'b0, rx_sel});
            tx_lvl = ucil_lvl({table_sel, 1'b1, tx_sel});
        end
    end
endmodule : ucil_trig_sel

// ---- rtl/ucil_rx_tmo.sv ----
// Receive idle timer counting bit ticks while data waits
`timescale 1ns/1ps
`include "ucil_map.svh"
module ucil_rx_tmo
    import ucil_pkg::*;
#(
    parameter int CHAR_BITS = 10
) (
    input wire logic clk, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic bit_tick, // One pulse per bit time
    input wire logic arm, // Data waiting in receive FIFO
    input wire logic restart, // Character received or data read
    output logic expire // One cycle at timeout
);
    localparam int LIMIT =
        `UCIL_TMO_CHARS * CHAR_BITS + `UCIL_TMO_EXTRA_BITS;
    if (LIMIT > 255) begin : g_chk
        $error("timeout exceeds counter");
    end
    ucil_tmo_type s, nxt;

    always_comb begin
        nxt = s;
        nxt.expire = 1'b0;
        if (!arm || restart) begin
            nxt.cnt = 8'h00;
            nxt.fired = 1'b0;
        end else if (bit_tick && !s.fired) begin
            nxt.cnt = s.cnt + 8'h01;
            if (nxt.cnt == 8'(LIMIT)) begin
                nxt.expire = 1'b1;
                nxt.fired = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= nxt;
        end
    end
    assign expire = s.expire;

    // Fires only at the exact count
    AST_TMO_COUNT: assert property (@(posedge clk) disable iff (srst)
        $rose(s.expire) |-> s.cnt == 8'(LIMIT))
        else $error("timeout fired at wrong count");
endmodule : ucil_rx_tmo

// ---- rtl/ucil_top.sv ----
// Interrupt enable, source encoding and trigger logic of one channel
`timescale 1ns/1ps
`include "ucil_map.svh"
// Function
// - CTS rising edge interrupt, enable unlocked only
// - RTS output rising edge interrupt
// - Received Xoff raises an interrupt
// - Any modem delta bit interrupts
// - Error char interrupts, again at head
// - Line status shows head flags, FIFO error
// - Transmit ready below trigger and on empty
// - Half-duplex waits for shifter empty, FIFO mode only
// - Receive data ready by hold or trigger
// - Read returns highest pending source
// - Six-bit priority source codes
// - Timeout four chars plus twelve bits
// - Status reads clear their interrupts
// - Data ready holds until below trigger
// - Transmit ready cleared by read or write
// - Flow char clears by read, special char also by next char
// - Flow pin change under auto flow control
// - Wake-up indication cleared by global read
// - Source bits 7:6 show FIFO enable
// - Source bit 0 low when pending
// - Receive trigger selection, shared table
// - Transmit trigger selection, unlocked only
// - Table choice from feature control bits
module ucil_top
    import ucil_pkg::*;
#(
    parameter int CNT_W = 7,
    parameter int CHAR_BITS = 10
) (
    input wire logic clk, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic [3:0] addr, // Register address
    input wire logic [7:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [7:0] rdata_ff, // Read data, cycle after strobe
    input wire logic [CNT_W-1:0] rx_count, // Receive FIFO level
    input wire logic [CNT_W-1:0] tx_count, // Transmit FIFO level
    input wire logic rx_err_char, // Errored char arrived pulse
    input wire logic [3:0] head_err, // Break/frame/parity/overrun
    input wire logic fifo_err_any, // Any errored byte in FIFO
    input wire logic tx_hold_empty, // Holding register empty
    input wire logic tx_shift_empty, // Shift register empty
    input wire logic [3:0] mstat_delta, // Modem delta bits
    input wire logic xoff_det, // Xoff received pulse
    input wire logic xon_det, // Xon received pulse
    input wire logic spc_det, // Special char received pulse
    input wire logic char_rx, // Any char received pulse
    input wire logic cts_n, // Clear-to-send input level
    input wire logic dsr_n, // Data-set-ready input level
    input wire logic rts_n, // Own request-to-send level
    input wire logic dtr_n, // Own terminal-ready level
    input wire logic wake_evt, // Channel left sleep pulse
    input wire logic gint_rd, // Global source read pulse
    input wire logic bit_tick, // One pulse per bit time
    output logic irq_ff, // Interrupt pending, high
    output logic wake_ind_ff, // Wake-up indication
    output logic fifo_en_ff, // FIFOs enabled
    output logic rx_rst_ff, // Receive FIFO reset pulse
    output logic tx_rst_ff // Transmit FIFO reset pulse
);
    if (CNT_W < 7 || CNT_W > 8) begin : g_chk
        $error("CNT_W must be 7 or 8");
    end
    ucil_state_type s, nxt;
    logic [7:0] rx_lvl;
    logic [7:0] tx_lvl;
    logic tmo_hit;
    logic [7:0] rxc;
    logic [7:0] txc;
    logic rd_src;
    logic rd_lstat;
    logic rd_mstat;
    logic rd_hold;
    logic rxd_p;
    logic ms_p;
    logic [5:0] code;
    logic [7:0] lstat_val;

    // Highest pending source, level 1 first
    function automatic logic [5:0] ucil_code(input logic [6:0] p);
        if (p[0]) ucil_code = `UCIL_SRC_LS;
        else if (p[1]) ucil_code = `UCIL_SRC_RXD;
        else if (p[2]) ucil_code = `UCIL_SRC_TMO;
        else if (p[3]) ucil_code = `UCIL_SRC_TX;
        else if (p[4]) ucil_code = `UCIL_SRC_MS;
        else if (p[5]) ucil_code = `UCIL_SRC_XCH;
        else if (p[6]) ucil_code = `UCIL_SRC_PIN;
        else ucil_code = `UCIL_SRC_NONE;
    endfunction : ucil_code

    // Trigger levels from active table
    ucil_trig_sel u_trig (
        .table_sel(s.fctl[7:6]),
        .rx_sel(s.rx_sel),
        .tx_sel(s.tx_sel),
        .rxlvl(s.rxlvl),
        .txlvl(s.txlvl),
        .rx_lvl(rx_lvl),
        .tx_lvl(tx_lvl)
    );

    // Receive idle timer
    ucil_rx_tmo #(.CHAR_BITS(CHAR_BITS)) u_tmo (
        .clk(clk),
        .srst(srst),
        .bit_tick(bit_tick),
        .arm(s.fifo_en && rx_count != '0),
        .restart(char_rx || rd_hold),
        .expire(tmo_hit)
    );

    // Decoded reads and live source levels
    always_comb begin
        rxc = 8'(rx_count);
        txc = 8'(tx_count);
        rd_src = rd && addr == `UCIL_ADR_SRC;
        rd_lstat = rd && addr == `UCIL_ADR_LSTAT;
        rd_mstat = rd && addr == `UCIL_ADR_MSTAT;
        rd_hold = rd && addr == `UCIL_ADR_RXHOLD;
        rxd_p = s.mask[`UCIL_MASK_RX] &&
            (s.fifo_en ? rxc >= rx_lvl : rxc != 8'h00);
        ms_p = s.mask[`UCIL_MASK_MS] && (|mstat_delta);
        code = ucil_code({s.pin_p, s.xch_p | s.spc_p, ms_p, s.tx_p,
            s.tmo_p, rxd_p, s.ls_p});
        // Head byte flags plus FIFO error
        lstat_val = {fifo_err_any, tx_hold_empty && tx_shift_empty,
            tx_hold_empty, head_err, rxc != 8'h00};
    end

    // Next state of the whole block
    always_comb begin
        logic tx_ev;
        logic above;
        logic empty_c;
        logic pin_in;
        logic pin_out;
        logic head_now;
        tx_ev = 1'b0;
        above = txc >= tx_lvl;
        empty_c = tx_count == '0 &&
            (!s.fctl[`UCIL_FCTL_AUTO485] || tx_shift_empty);
        // Pin pair chosen by modem control
        pin_in = s.mctl[`UCIL_MCTL_PAIR] ? dsr_n : cts_n;
        pin_out = s.mctl[`UCIL_MCTL_PAIR] ? dtr_n : rts_n;
        head_now = |head_err;
        nxt = s;
        nxt.rx_rst = 1'b0;
        nxt.tx_rst = 1'b0;
        nxt.cts_q = pin_in;
        nxt.rts_q = pin_out;
        nxt.head_q = head_now;
        nxt.hold_q = tx_hold_empty;
        nxt.empty_q = empty_c;
        nxt.above_q = above;
        nxt.rdata = 8'h00;

        // Register writes
        if (wr) begin
            unique case (addr)
                `UCIL_ADR_MASK: begin
                    nxt.mask = wdata;
                    nxt.mask[`UCIL_MASK_RSVD] = 1'b0;
                    if (!s.enh[`UCIL_ENH_UNLOCK]) begin
                        nxt.mask[7:5] = s.mask[7:5];
                    end
                end
                `UCIL_ADR_SRC: begin
                    nxt.fifo_en = wdata[`UCIL_FIFO_EN];
                    if (wdata[`UCIL_FIFO_EN]) begin
                        nxt.rx_sel = wdata[7:6];
                        if (s.enh[`UCIL_ENH_UNLOCK]) begin
                            nxt.tx_sel = wdata[5:4];
                        end
                        nxt.rx_rst = wdata[`UCIL_FIFO_RXRST];
                        nxt.tx_rst = wdata[`UCIL_FIFO_TXRST];
                    end
                end
                `UCIL_ADR_MCTL: nxt.mctl = wdata;
                `UCIL_ADR_FCTL: nxt.fctl = wdata;
                `UCIL_ADR_ENH: nxt.enh = wdata;
                `UCIL_ADR_TXLVL: nxt.txlvl = wdata;
                `UCIL_ADR_RXLVL: nxt.rxlvl = wdata;
                default: ;
            endcase
        end

        // Register reads, answered next cycle
        if (rd) begin
            unique case (addr)
                `UCIL_ADR_MASK: nxt.rdata = s.mask;
                `UCIL_ADR_SRC: nxt.rdata = {{2{s.fifo_en}}, code};
                `UCIL_ADR_LSTAT: nxt.rdata = lstat_val;
                `UCIL_ADR_MCTL: nxt.rdata = s.mctl;
                `UCIL_ADR_FCTL: nxt.rdata = s.fctl;
                `UCIL_ADR_ENH: nxt.rdata = s.enh;
                default: nxt.rdata = 8'h00;
            endcase
        end

        // Error char, and again at head
        nxt.ls_p = (s.ls_p && !rd_lstat) || (s.mask[`UCIL_MASK_LS] &&
            (rx_err_char || (head_now && !s.head_q)));
        // Timer expiry, cleared by data read
        nxt.tmo_p = (s.tmo_p && !rd_hold) ||
            (tmo_hit && s.mask[`UCIL_MASK_RX]);
        // FIFO mode: below trigger, then again on empty; otherwise holding register empty edge
        if (s.fifo_en) begin
            tx_ev = (s.above_q && !above) || (empty_c && !s.empty_q);
        end else begin
            tx_ev = tx_hold_empty && !s.hold_q;
        end
        // Cleared by source read or data write
        nxt.tx_p = (s.tx_p && !(rd_src && code == `UCIL_SRC_TX) &&
            !(wr && addr == `UCIL_ADR_RXHOLD)) ||
            (tx_ev && s.mask[`UCIL_MASK_TX]);
        // Flow chars clear on source read
        nxt.xch_p = (s.xch_p && !(rd_src && code == `UCIL_SRC_XCH)) ||
            (s.mask[`UCIL_MASK_XOFF] && (xoff_det || xon_det));
        // Special char also clears on next char
        nxt.spc_p = (s.spc_p && !(rd_src && code == `UCIL_SRC_XCH) &&
            !char_rx) || (s.mask[`UCIL_MASK_XOFF] && spc_det);
        nxt.pin_p = (s.pin_p && !rd_mstat) ||
            (pin_in && !s.cts_q && s.mask[`UCIL_MASK_CTS] &&
            s.enh[`UCIL_ENH_AUTO_CTS]) ||
            (pin_out && !s.rts_q && s.mask[`UCIL_MASK_RTS] &&
            s.enh[`UCIL_ENH_AUTO_RTS]);
        nxt.wake = (s.wake && !gint_rd) || wake_evt;
        nxt.irq = nxt.ls_p || nxt.tmo_p || nxt.tx_p || nxt.xch_p ||
            nxt.spc_p || nxt.pin_p || rxd_p || ms_p;
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
            s.rdata <= `UCIL_RST_REG;
            // Pins idle high, so no false edge at release
            s.cts_q <= 1'b1;
            s.rts_q <= 1'b1;
        end else begin
            s <= nxt;
        end
    end

    // Outputs straight from state
    assign rdata_ff = s.rdata;
    assign irq_ff = s.irq;
    assign wake_ind_ff = s.wake;
    assign fifo_en_ff = s.fifo_en;
    assign rx_rst_ff = s.rx_rst;
    assign tx_rst_ff = s.tx_rst;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence seq_src_rd;
        rd && addr == `UCIL_ADR_SRC;
    endsequence
    sequence seq_tx_drain;
        s.fifo_en && s.mask[`UCIL_MASK_TX] && !wr ##1
            tx_count == '0 && !s.empty_q &&
            (!s.fctl[`UCIL_FCTL_AUTO485] || tx_shift_empty);
    endsequence

    AST_CTS_RISE: assert property ($rose(cts_n) && !s.mctl[2] &&
        s.mask[7] && s.enh[7] |=> s.pin_p ##1 irq_ff)
        else $error("input rise did not interrupt");
    AST_RTS_RISE: assert property ($rose(rts_n) && !s.mctl[2] &&
        s.mask[6] && s.enh[6] |=> s.pin_p)
        else $error("output rise did not interrupt");
    AST_MASK_LOCK: assert property (wr && addr == `UCIL_ADR_MASK &&
        !s.enh[4] |=> s.mask[7:5] == $past(s.mask[7:5]))
        else $error("locked enables changed");
    AST_XOFF: assert property (xoff_det && s.mask[5] |=>
        s.xch_p ##1 irq_ff)
        else $error("xoff did not interrupt");
    AST_MODEM: assert property (s.mask[3] && (|mstat_delta)
        |=> irq_ff)
        else $error("modem delta did not interrupt");
    AST_LS_SET: assert property (rx_err_char && s.mask[2] |=>
        s.ls_p && irq_ff)
        else $error("error char did not interrupt");
    AST_LS_VIEW: assert property (rd && addr == `UCIL_ADR_LSTAT |=>
        rdata_ff[7] == $past(fifo_err_any) &&
        rdata_ff[4:1] == $past(head_err))
        else $error("line status view wrong");
    AST_TX_EMPTY: assert property (seq_tx_drain |=> s.tx_p)
        else $error("empty did not raise transmit ready");
    AST_SRC_FIFO: assert property (seq_src_rd |=>
        rdata_ff[7:6] == {2{$past(s.fifo_en)}})
        else $error("fifo enable bits wrong");
    AST_SRC_NONE: assert property (seq_src_rd and (!irq_ff &&
        !rxd_p && !ms_p) |=> rdata_ff[5:0] == `UCIL_SRC_NONE)
        else $error("idle code wrong");
    AST_LS_CLR: assert property (rd && addr == `UCIL_ADR_LSTAT &&
        !rx_err_char && !(|head_err) |=> !s.ls_p)
        else $error("line status read did not clear");
    AST_WAKE: assert property (wake_evt |=> wake_ind_ff[*2] or
        (wake_ind_ff ##1 $past(gint_rd)))
        else $error("wake indication lost");

    // Paired pins, flow chars, timer clear, half-duplex hold
    AST_DSR_RISE: assert property ($rose(dsr_n) && s.mctl[2] &&
        $past(s.mctl[2]) && s.mask[7] && s.enh[7] |=> s.pin_p)
        else $error("paired input rise did not interrupt");
    AST_DTR_RISE: assert property ($rose(dtr_n) && s.mctl[2] &&
        $past(s.mctl[2]) && s.mask[6] && s.enh[6] |=> s.pin_p)
        else $error("paired output rise did not interrupt");
    AST_XON: assert property (xon_det && s.mask[5] |=> s.xch_p)
        else $error("xon did not interrupt");
    AST_SPC_CLR: assert property (char_rx && !spc_det |=> !s.spc_p)
        else $error("next char did not clear special");
    AST_TMO_CLR: assert property (rd_hold && !tmo_hit |=> !s.tmo_p)
        else $error("data read did not clear timeout");
    AST_HALF_DUPLEX: assert property (s.fifo_en &&
        s.fctl[`UCIL_FCTL_AUTO485] && !tx_shift_empty && !s.above_q &&
        !s.tx_p |=> !s.tx_p)
        else $error("transmit ready before shifter empty");
endmodule : ucil_top

// ---- tb/ucil_host.sv ----
// Host processor model speaking the channel register port
`timescale 1ns/1ps
module ucil_host (
    input wire logic clk, // System clock
    input wire logic [7:0] rdata_ff, // Read data from the channel
    output logic [3:0] addr, // Register address
    output logic [7:0] wdata, // Write data
    output logic wr, // Write strobe
    output logic rd // Read strobe
);
    // Bus idle at time zero
    initial begin
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end

    // One-cycle write, taken at the next edge
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic wr_fifo(input logic [7:0] d);
        wr_reg(4'h2, d | 8'h01);
    endtask : wr_fifo

    // One-cycle read, data sampled in the following cycle
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata_ff;
    endtask : rd_reg
endmodule : ucil_host

// ---- tb/tb_top.sv ----
// Register-level tests of the channel interrupt logic
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    n_errors++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
    import ucil_pkg::*;
    logic clk, srst, wr, rd, rx_err_char, fifo_err_any, tx_hold_empty;
    logic tx_shift_empty, xoff_det, cts_n, wake_evt, gint_rd, bit_tick;
    logic xon_det, spc_det, char_rx, dsr_n, rts_n, dtr_n;
    logic irq_ff, wake_ind_ff, fifo_en_ff, rx_rst_ff, tx_rst_ff;
    logic [3:0] addr, head_err, mstat_delta;
    logic [7:0] wdata, rdata_ff, d;
    logic [6:0] rx_count, tx_count;
    int n_errors = 0;
    int n_compared = 0;

    // Clock, 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ucil_host u_host (.clk(clk), .rdata_ff(rdata_ff), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd));

    ucil_top #(.CNT_W(7), .CHAR_BITS(2)) u_dut (.clk(clk), .srst(srst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff),
        .rx_count(rx_count), .tx_count(tx_count), .rx_err_char(rx_err_char),
        .head_err(head_err), .fifo_err_any(fifo_err_any),
        .tx_hold_empty(tx_hold_empty), .tx_shift_empty(tx_shift_empty),
        .mstat_delta(mstat_delta), .xoff_det(xoff_det), .xon_det(xon_det),
        .spc_det(spc_det), .char_rx(char_rx), .cts_n(cts_n), .dsr_n(dsr_n),
        .rts_n(rts_n), .dtr_n(dtr_n), .wake_evt(wake_evt), .gint_rd(gint_rd),
        .bit_tick(bit_tick), .irq_ff(irq_ff), .wake_ind_ff(wake_ind_ff),
        .fifo_en_ff(fifo_en_ff), .rx_rst_ff(rx_rst_ff),
        .tx_rst_ff(tx_rst_ff));

    // Counts and verdict, then stop
    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // Settle then read the source register
    task automatic src(input logic [7:0] e);
        cyc(3);
        u_host.rd_reg(4'h2, d);
        `CHK("source", e, d)
    endtask : src

    // Pin change shown, then cleared by modem status read
    task automatic pin_chk();
        src(8'hE0);
        u_host.rd_reg(4'h6, d);
        src(8'hC1);
    endtask : pin_chk

    task automatic done(input string nm);
        $display("Test %s finished", nm);
    endtask : done

    // Hang guard
    initial begin
        #(25ns * 20000);
        n_errors++;
        finish_test();
    end

    initial begin
        {rx_err_char, fifo_err_any, tx_hold_empty, tx_shift_empty} = 4'h0;
        {xoff_det, cts_n, wake_evt, gint_rd, bit_tick} = 5'h00;
        {xon_det, spc_det, char_rx, dsr_n, rts_n, dtr_n} = 6'h00;
        head_err = 4'h0;
        mstat_delta = 4'h0;
        rx_count = 7'h00;
        tx_count = 7'h00;
        srst = 1'b1;
        cyc(4);
        srst <= 1'b0;
        src(8'h01);
        `CHK("irq", 1'b0, irq_ff)
        done("reset");
        // Upper mask bits locked until unlock, bit 4 reserved
        u_host.wr_reg(4'h1, 8'hFF);
        u_host.rd_reg(4'h1, d);
        `CHK("mask locked", 8'h0F, d)
        u_host.wr_reg(4'h9, 8'h10);
        u_host.wr_reg(4'h1, 8'hFF);
        u_host.rd_reg(4'h1, d);
        `CHK("mask open", 8'hEF, d)
        u_host.wr_reg(4'h1, 8'h0C);
        u_host.wr_fifo(8'h06);
        #1;
        `CHK("fifo ctl", 3'h7, {fifo_en_ff, rx_rst_ff, tx_rst_ff})
        src(8'hC1);
        `CHK("fifo reset end", 2'h0, {rx_rst_ff, tx_rst_ff})
        done("mask");
        // Errored char behind a clean head byte
        @(posedge clk);
        fifo_err_any <= 1'b1;
        rx_err_char <= 1'b1;
        @(posedge clk);
        rx_err_char <= 1'b0;
        mstat_delta <= 4'h4;
        src(8'hC6);
        `CHK("irq", 1'b1, irq_ff)
        u_host.rd_reg(4'h5, d);
        `CHK("line status", 8'h80, d)
        src(8'hC0);
        @(posedge clk);
        mstat_delta <= 4'h0;
        head_err <= 4'h2;
        src(8'hC6);
        u_host.rd_reg(4'h5, d);
        `CHK("line status", 8'h84, d)
        src(8'hC1);
        @(posedge clk);
        head_err <= 4'h0;
        fifo_err_any <= 1'b0;
        done("line");
        // Receive trigger level 4 from the default table
        u_host.wr_reg(4'h1, 8'h01);
        u_host.wr_fifo(8'h40);
        @(posedge clk);
        rx_count <= 7'd3;
        src(8'hC1);
        @(posedge clk);
        rx_count <= 7'd4;
        src(8'hC4);
        @(posedge clk);
        rx_count <= 7'd3;
        src(8'hC1);
        @(posedge clk);
        bit_tick <= 1'b1;
        cyc(30);
        bit_tick <= 1'b0;
        src(8'hCC);
        u_host.rd_reg(4'h0, d);
        src(8'hC1);
        @(posedge clk);
        rx_count <= 7'd0;
        done("receive");
        // Transmit ready in FIFO mode, trigger level one
        u_host.wr_reg(4'h1, 8'h02);
        @(posedge clk);
        tx_count <= 7'd2;
        cyc(2);
        tx_count <= 7'd0;
        src(8'hC2);
        src(8'hC1);
        @(posedge clk);
        tx_count <= 7'd1;
        cyc(2);
        tx_count <= 7'd0;
        src(8'hC2);
        u_host.wr_reg(4'h0, 8'h5A);
        src(8'hC1);
        // Programmed level 4, half-duplex waits for shifter
        u_host.wr_reg(4'hA, 8'h04);
        u_host.wr_reg(4'h8, 8'hE0);
        @(posedge clk);
        tx_count <= 7'd5;
        cyc(2);
        tx_count <= 7'd2;
        src(8'hC2);
        src(8'hC1);
        @(posedge clk);
        tx_count <= 7'd0;
        src(8'hC1);
        @(posedge clk);
        tx_shift_empty <= 1'b1;
        src(8'hC2);
        u_host.wr_reg(4'h0, 8'h00);
        src(8'hC1);
        u_host.wr_reg(4'h8, 8'h00);
        // Non-FIFO mode, holding register empty edge
        u_host.wr_reg(4'h2, 8'h00);
        @(posedge clk);
        tx_hold_empty <= 1'b1;
        src(8'h02);
        src(8'h01);
        u_host.wr_fifo(8'h00);
        done("transmit");
        // Xoff and flow pin change
        u_host.wr_reg(4'h1, 8'hA0);
        @(posedge clk);
        xoff_det <= 1'b1;
        @(posedge clk);
        xoff_det <= 1'b0;
        src(8'hD0);
        src(8'hC1);
        u_host.wr_reg(4'h9, 8'h90);
        @(posedge clk);
        cts_n <= 1'b1;
        pin_chk();
        @(posedge clk);
        xon_det <= 1'b1;
        @(posedge clk);
        xon_det <= 1'b0;
        src(8'hD0);
        src(8'hC1);
        @(posedge clk);
        spc_det <= 1'b1;
        @(posedge clk);
        spc_det <= 1'b0;
        src(8'hD0);
        @(posedge clk);
        spc_det <= 1'b1;
        @(posedge clk);
        spc_det <= 1'b0;
        char_rx <= 1'b1;
        @(posedge clk);
        char_rx <= 1'b0;
        src(8'hC1);
        u_host.wr_reg(4'h9, 8'hD0);
        u_host.wr_reg(4'h1, 8'hE0);
        @(posedge clk);
        rts_n <= 1'b1;
        pin_chk();
        u_host.wr_reg(4'h4, 8'h04);
        @(posedge clk);
        dsr_n <= 1'b1;
        pin_chk();
        @(posedge clk);
        dtr_n <= 1'b1;
        pin_chk();
        done("flow");
        // Wake-up indication
        @(posedge clk);
        wake_evt <= 1'b1;
        @(posedge clk);
        wake_evt <= 1'b0;
        cyc(2);
        `CHK("wake", 1'b1, wake_ind_ff)
        gint_rd <= 1'b1;
        @(posedge clk);
        gint_rd <= 1'b0;
        cyc(2);
        `CHK("wake", 1'b0, wake_ind_ff)
        done("wake");
        finish_test();
    end
endmodule : tb_top
